//--- receiver_tuning_consts.svh
// Constants for the receiver tuning register pair: addresses, fields, resets, timing.
// Assumes inclusion by bare name from the design files; holds definitions only.
`ifndef RECEIVER_TUNING_CONSTS_SVH
`define RECEIVER_TUNING_CONSTS_SVH

// Register addresses on the serial control interface.
`define RT_ADDR_STARTUP 7'h32
`define RT_ADDR_DEMOD 7'h33

// Power-on values.
`define RT_STARTUP_RESET 8'h49
`define RT_DEMOD_RESET 8'h02

// Startup and PLL tuning field positions.
`define RT_OSC_SEL_MSB 7
`define RT_OSC_SEL_LSB 6
`define RT_ASK_MID_BIT 5
`define RT_RSV_MSB 4
`define RT_RSV_LSB 3
`define RT_FRAC_BIT 2
`define RT_LOCK_SEL_MSB 1
`define RT_LOCK_SEL_LSB 0

// Demodulator and RSSI tuning field positions.
`define RT_DUAL_LIM_BIT 7
`define RT_WIDE_RANGE_BIT 6
`define RT_EDGE_WIN_BIT 5
`define RT_CHIP_SHORT_BIT 4
`define RT_RSSI_MSB_BIT 3
`define RT_QUICK_SETTLE_BIT 2
`define RT_CAP_MSB 1
`define RT_CAP_LSB 0

// Timing: one microsecond tick derived from the clock period.
`define RT_US_NS 1000
`define RT_CLK_PERIOD_NS 10
`define RT_US_CYCLES (`RT_US_NS / `RT_CLK_PERIOD_NS)
`define RT_OSC_STEP_US 256
`define RT_LOCK_STEP_US 16

// Demodulator delay-line lengths per code of bits 7:6.
`define RT_DELAY_EL_00 6'd40
`define RT_DELAY_EL_01 6'd13
`define RT_DELAY_EL_10 6'd20
`define RT_DELAY_EL_11 6'd7

// Other decoded figures.
`define RT_EDGE_SAMPLES_NARROW 3'd2
`define RT_EDGE_SAMPLES_WIDE 3'd4
`define RT_CHIP_HALVES_LONG 3'd7
`define RT_CHIP_HALVES_SHORT 3'd5
`define RT_RSSI_B5_SLOW 2'd3
`define RT_RSSI_B4_SLOW 2'd1
`define RT_RSSI_B_EVEN 2'd2
`define RT_SETTLE_TAU_FULL 3'd4
`define RT_SETTLE_TAU_QUICK 3'd2
`define RT_CAP_PF_00 4'd0
`define RT_CAP_PF_01 4'd2
`define RT_CAP_PF_10 4'd5
`define RT_CAP_PF_11 4'd12

`endif

//--- receiver_tuning_pkg.sv
// Types shared by the receiver tuning register design.
// Assumes nothing of its surroundings.
package receiver_tuning_pkg;

    // Phases of one serial access frame.
    typedef enum logic [1:0] {PH_IDLE, PH_ADDR, PH_DATA, PH_DONE} spi_phase_e;

    typedef logic [7:0] reg_byte_t;

endpackage

//--- startup_delay_timer.sv
// Microsecond delay timer used by the startup sequence after a ready or lock level.
// Assumes a one-cycle microsecond tick and a synchronous, same-clock start level.
`timescale 1ns/1ps
`include "receiver_tuning_consts.svh"

module startup_delay_timer (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic tick_i,
    input wire logic start_i,
    input wire logic [10:0] target_i,
    output logic done_o
);

    logic [10:0] cnt;

    // Count microseconds while the start level holds; losing it restarts the wait.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt <= 11'h000;
            done_o <= 1'b0;
        end else if (!start_i) begin
            cnt <= 11'h000;
            done_o <= 1'b0;
        end else if (tick_i && !done_o) begin
            cnt <= cnt + 11'h001;
            if (cnt == target_i - 11'h001) begin
                done_o <= 1'b1;
            end
        end
    end

    property p_done_at_target;
        @(posedge clk_i) disable iff (!rst_n_i)
        $rose(done_o) |-> $past(tick_i) && ($past(cnt) == target_i - 11'h001);
    endproperty
    a_done_at_target: assert property (p_done_at_target)
        else $error("Delay ended before its selected count.");

    property p_done_drops;
        @(posedge clk_i) disable iff (!rst_n_i)
        !start_i |=> !done_o;
    endproperty
    a_done_drops: assert property (p_done_drops)
        else $error("Delay done held without its start level.");

endmodule

//--- receiver_tuning_config_regs.sv
// Two tuning registers behind the serial control interface, with decoded settings.
// Assumes a microcontroller drives clock, enable and data pins asynchronously to clk_i.
`timescale 1ns/1ps
`include "receiver_tuning_consts.svh"

// How it works
// - After the oscillator reports ready, startup waits 256, 512, 768 or 1024 us chosen by the settle field.
// - After reset the settle field holds 01, giving the 512 us wait.
// - The ASK mid-reset bit picks whether the baseband filter resets to zero or to RSSI mid-range.
// - The fractional-N disable bit takes the PLL out of fractional-N operation.
// - After PLL lock, startup waits a further 16, 32, 48 or 64 us chosen by the lock field.
// - The dual-limiter bit makes the FSK demodulator use both I and Q limiters.
// - The wide-range bit picks the 200 to 400 kHz span or the 0 to 600 kHz span.
// - Demodulator bits 7:6 set 40, 13, 20 or 7 delay elements, bit 7 picking a 600 kHz centre.
// - The window bit picks 2 or 4 samples for edge-detection amplitude.
// - The chip-timing check times out after 3.5 chips, or 2.5 chips with the short bit set.
// - The RSSI converter spends 3 and 1 clocks on bits 5 and 4, or 2 and 2 with the timing bit set.
// - The RSSI filter settle wait lasts 4 time-constants, or 2 with the quick bit set.
// - The capacitor trim field selects none, 2 pF, 5 pF or 12 pF for the RSSI low-pass filter.
module receiver_tuning_config_regs #(
    parameter int unsigned US_CYCLES = `RT_US_CYCLES
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic spi_clk_i,
    input wire logic spi_en_i,
    input wire logic spi_din_i,
    input wire logic osc_ready_flag_i,
    input wire logic pll_lock_i,
    output logic spi_dout_o,
    output logic spi_dout_oe_o,
    output logic osc_settle_done_o,
    output logic lock_settle_done_o,
    output logic ask_filter_mid_reset_o,
    output logic frac_n_disable_o,
    output logic demod_dual_limiter_sel_o,
    output logic demod_wide_range_o,
    output logic demod_center_600k_o,
    output logic [5:0] demod_delay_elements_o,
    output logic edge_window_wide_o,
    output logic [2:0] edge_sample_count_o,
    output logic chip_timeout_short_o,
    output logic [2:0] chip_timeout_half_chips_o,
    output logic rssi_msb_timing_sel_o,
    output logic [1:0] rssi_bit5_clocks_o,
    output logic [1:0] rssi_bit4_clocks_o,
    output logic rssi_quick_settle_o,
    output logic [2:0] rssi_settle_tau_o,
    output logic [1:0] rssi_cap_trim_o,
    output logic [3:0] rssi_cap_pf_o
);

    logic [1:0] rst_sync;
    logic rst_n;
    logic [2:0] pin_s1;
    logic [2:0] pin_s2;
    logic [2:0] pin_s3;
    logic [2:0] pin_f;
    logic sclk_d;
    logic sclk_rise;
    logic sclk_fall;
    receiver_tuning_pkg::spi_phase_e phase;
    logic [2:0] bit_cnt;
    logic [7:0] shift_in;
    logic rd_flag;
    logic [6:0] addr;
    logic [7:0] sh_out;
    logic wr_stb;
    logic [7:0] wr_data;
    receiver_tuning_pkg::reg_byte_t startup_reg;
    receiver_tuning_pkg::reg_byte_t demod_reg;
    logic [6:0] us_cnt;
    logic us_tick;
    logic [10:0] osc_target;
    logic [10:0] lock_target;

    // Register read decode; an unmapped address reads as zero.
    function automatic logic [7:0] read_reg(input logic [6:0] a, input logic [7:0] s, input logic [7:0] d);
        logic [7:0] v;
        v = 8'h00;
        if (a == `RT_ADDR_STARTUP) begin
            v = s;
        end else if (a == `RT_ADDR_DEMOD) begin
            v = d;
        end
        return v;
    endfunction

    // Wait length in microseconds: (code + 1) steps.
    function automatic logic [10:0] delay_target(input logic [1:0] sel, input logic [10:0] step);
        logic [21:0] prod;
        prod = 22'({9'h000, sel} + 11'h001) * 22'(step);
        return prod[10:0];
    endfunction

    // Delay-line length per demodulator code.
    function automatic logic [5:0] delay_elements(input logic [1:0] code);
        logic [5:0] n;
        unique case (code)
            2'b00: n = `RT_DELAY_EL_00;
            2'b01: n = `RT_DELAY_EL_01;
            2'b10: n = `RT_DELAY_EL_10;
            2'b11: n = `RT_DELAY_EL_11;
        endcase
        return n;
    endfunction

    // Typical filter capacitance per trim code.
    function automatic logic [3:0] cap_pf(input logic [1:0] code);
        logic [3:0] c;
        unique case (code)
            2'b00: c = `RT_CAP_PF_00;
            2'b01: c = `RT_CAP_PF_01;
            2'b10: c = `RT_CAP_PF_10;
            2'b11: c = `RT_CAP_PF_11;
        endcase
        return c;
    endfunction

    // Reset release through two flip-flops so every flop leaves reset on the same edge.
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_sync <= 2'b00;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n);

    // Pins {clock, enable, data} pass three stages; a new level counts once stages two and three agree.
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1 <= 3'h0;
            pin_s2 <= 3'h0;
            pin_s3 <= 3'h0;
            pin_f <= 3'h0;
            sclk_d <= 1'b0;
        end else begin
            pin_s1 <= {spi_clk_i, spi_en_i, spi_din_i};
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
            pin_f <= (pin_s3 & ~(pin_s2 ^ pin_s3)) | (pin_f & (pin_s2 ^ pin_s3));
            sclk_d <= pin_f[2];
        end
    end
    assign sclk_rise = pin_f[2] & ~sclk_d;
    assign sclk_fall = ~pin_f[2] & sclk_d;

    // Frame: read flag and 7-bit address, then 8 data bits, MSB first, sampled on rising clock.
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            phase <= receiver_tuning_pkg::PH_IDLE;
            bit_cnt <= 3'h0;
            shift_in <= 8'h00;
            rd_flag <= 1'b0;
            addr <= 7'h00;
            wr_stb <= 1'b0;
            wr_data <= 8'h00;
        end else begin
            wr_stb <= 1'b0;
            if (!pin_f[1]) begin
                phase <= receiver_tuning_pkg::PH_IDLE;
                bit_cnt <= 3'h0;
            end else if (phase == receiver_tuning_pkg::PH_IDLE) begin
                phase <= receiver_tuning_pkg::PH_ADDR;
            end else if (sclk_rise && phase != receiver_tuning_pkg::PH_DONE) begin
                shift_in <= {shift_in[6:0], pin_f[0]};
                bit_cnt <= bit_cnt + 3'h1;
                if (bit_cnt == 3'h7) begin
                    unique case (phase)
                        receiver_tuning_pkg::PH_ADDR: begin
                            rd_flag <= shift_in[6];
                            addr <= {shift_in[5:0], pin_f[0]};
                            phase <= receiver_tuning_pkg::PH_DATA;
                        end
                        receiver_tuning_pkg::PH_DATA: begin
                            wr_stb <= !rd_flag;
                            wr_data <= {shift_in[6:0], pin_f[0]};
                            phase <= receiver_tuning_pkg::PH_DONE;
                        end
                        default: phase <= receiver_tuning_pkg::PH_DONE;
                    endcase
                end
            end
        end
    end

    // Read data loads after the address byte and shifts out on falling clock edges.
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            sh_out <= 8'h00;
            spi_dout_o <= 1'b0;
            spi_dout_oe_o <= 1'b0;
        end else begin
            if (phase == receiver_tuning_pkg::PH_ADDR && sclk_rise && bit_cnt == 3'h7) begin
                sh_out <= read_reg({shift_in[5:0], pin_f[0]}, startup_reg, demod_reg);
            end else if (phase == receiver_tuning_pkg::PH_DATA && rd_flag && sclk_fall) begin
                spi_dout_o <= sh_out[7];
                sh_out <= {sh_out[6:0], 1'b0};
            end
            spi_dout_oe_o <= pin_f[1] && rd_flag && phase == receiver_tuning_pkg::PH_DATA;
        end
    end

    // The register pair; reserved bits store what is written and power up as 01.
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            startup_reg <= `RT_STARTUP_RESET;
            demod_reg <= `RT_DEMOD_RESET;
        end else if (wr_stb && addr == `RT_ADDR_STARTUP) begin
            startup_reg <= wr_data;
        end else if (wr_stb && addr == `RT_ADDR_DEMOD) begin
            demod_reg <= wr_data;
        end
    end

    // Startup and PLL settings; every output is registered so consumers see clean levels.
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            ask_filter_mid_reset_o <= 1'b0;
            frac_n_disable_o <= 1'b0;
        end else begin
            ask_filter_mid_reset_o <= startup_reg[`RT_ASK_MID_BIT];
            frac_n_disable_o <= startup_reg[`RT_FRAC_BIT];
        end
    end

    // Demodulator and RSSI settings, decoded into the figures the datapaths use.
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            demod_dual_limiter_sel_o <= 1'b0;
            demod_wide_range_o <= 1'b0;
            demod_center_600k_o <= 1'b0;
            demod_delay_elements_o <= `RT_DELAY_EL_00;
            edge_window_wide_o <= 1'b0;
            edge_sample_count_o <= `RT_EDGE_SAMPLES_NARROW;
            chip_timeout_short_o <= 1'b0;
            chip_timeout_half_chips_o <= `RT_CHIP_HALVES_LONG;
            rssi_msb_timing_sel_o <= 1'b0;
            rssi_bit5_clocks_o <= `RT_RSSI_B5_SLOW;
            rssi_bit4_clocks_o <= `RT_RSSI_B4_SLOW;
            rssi_quick_settle_o <= 1'b0;
            rssi_settle_tau_o <= `RT_SETTLE_TAU_FULL;
            rssi_cap_trim_o <= 2'b00;
            rssi_cap_pf_o <= `RT_CAP_PF_00;
        end else begin
            demod_dual_limiter_sel_o <= demod_reg[`RT_DUAL_LIM_BIT];
            demod_wide_range_o <= demod_reg[`RT_WIDE_RANGE_BIT];
            demod_center_600k_o <= demod_reg[`RT_DUAL_LIM_BIT];
            demod_delay_elements_o <= delay_elements(demod_reg[7:6]);
            edge_window_wide_o <= demod_reg[`RT_EDGE_WIN_BIT];
            edge_sample_count_o <= demod_reg[`RT_EDGE_WIN_BIT] ? `RT_EDGE_SAMPLES_WIDE
                                                               : `RT_EDGE_SAMPLES_NARROW;
            chip_timeout_short_o <= demod_reg[`RT_CHIP_SHORT_BIT];
            chip_timeout_half_chips_o <= demod_reg[`RT_CHIP_SHORT_BIT] ? `RT_CHIP_HALVES_SHORT
                                                                       : `RT_CHIP_HALVES_LONG;
            rssi_msb_timing_sel_o <= demod_reg[`RT_RSSI_MSB_BIT];
            rssi_bit5_clocks_o <= demod_reg[`RT_RSSI_MSB_BIT] ? `RT_RSSI_B_EVEN : `RT_RSSI_B5_SLOW;
            rssi_bit4_clocks_o <= demod_reg[`RT_RSSI_MSB_BIT] ? `RT_RSSI_B_EVEN : `RT_RSSI_B4_SLOW;
            rssi_quick_settle_o <= demod_reg[`RT_QUICK_SETTLE_BIT];
            rssi_settle_tau_o <= demod_reg[`RT_QUICK_SETTLE_BIT] ? `RT_SETTLE_TAU_QUICK
                                                                 : `RT_SETTLE_TAU_FULL;
            rssi_cap_trim_o <= demod_reg[`RT_CAP_MSB:`RT_CAP_LSB];
            rssi_cap_pf_o <= cap_pf(demod_reg[`RT_CAP_MSB:`RT_CAP_LSB]);
        end
    end

    // Microsecond tick; one divider serves both startup waits.
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            us_cnt <= 7'h00;
            us_tick <= 1'b0;
        end else begin
            us_tick <= (us_cnt == 7'(US_CYCLES - 1));
            us_cnt <= (us_cnt == 7'(US_CYCLES - 1)) ? 7'h00 : us_cnt + 7'h01;
        end
    end

    // Wait lengths follow the live fields; changing them mid-wait moves the end point.
    assign osc_target = delay_target(startup_reg[7:6], 11'(`RT_OSC_STEP_US));
    assign lock_target = delay_target(startup_reg[1:0], 11'(`RT_LOCK_STEP_US));

    startup_delay_timer u_osc_wait (
        .clk_i(clk_i),
        .rst_n_i(rst_n),
        .tick_i(us_tick),
        .start_i(osc_ready_flag_i),
        .target_i(osc_target),
        .done_o(osc_settle_done_o)
    );

    startup_delay_timer u_lock_wait (
        .clk_i(clk_i),
        .rst_n_i(rst_n),
        .tick_i(us_tick),
        .start_i(pll_lock_i),
        .target_i(lock_target),
        .done_o(lock_settle_done_o)
    );

    sequence s_startup_write;
        wr_stb && addr == `RT_ADDR_STARTUP;
    endsequence

    property p_reset_defaults;
        $rose(rst_n) |-> startup_reg == `RT_STARTUP_RESET && demod_reg == `RT_DEMOD_RESET;
    endproperty
    a_reset_defaults: assert property (p_reset_defaults)
        else $error("Tuning registers left reset with wrong values.");

    property p_osc_target;
        startup_reg[7:6] == 2'b01 |-> osc_target == 11'd512;
    endproperty
    a_osc_target: assert property (p_osc_target)
        else $error("Default oscillator wait is not 512 us.");

    property p_lock_target;
        startup_reg[1:0] == 2'b11 |-> lock_target == 11'd64;
    endproperty
    a_lock_target: assert property (p_lock_target)
        else $error("Longest lock wait is not 64 us.");

    property p_ask_follow;
        s_startup_write ##2 1'b1 |-> ask_filter_mid_reset_o == $past(wr_data[5], 2);
    endproperty
    a_ask_follow: assert property (p_ask_follow)
        else $error("ASK mid-reset output did not follow the write.");

    property p_frac_follow;
        s_startup_write ##2 1'b1 |-> frac_n_disable_o == $past(wr_data[2], 2);
    endproperty
    a_frac_follow: assert property (p_frac_follow)
        else $error("Fractional-N disable did not follow the write.");

    property p_delay_table;
        demod_reg[7:6] == 2'b11 |=> demod_delay_elements_o == 6'd7 && demod_center_600k_o && demod_wide_range_o;
    endproperty
    a_delay_table: assert property (p_delay_table)
        else $error("Code 11 does not give 7 delay elements.");

    property p_edge_window;
        edge_sample_count_o == (edge_window_wide_o ? 3'd4 : 3'd2);
    endproperty
    a_edge_window: assert property (p_edge_window)
        else $error("Edge sample count disagrees with window bit.");

    property p_chip_timeout;
        chip_timeout_half_chips_o == (chip_timeout_short_o ? 3'd5 : 3'd7);
    endproperty
    a_chip_timeout: assert property (p_chip_timeout)
        else $error("Chip timeout disagrees with short bit.");

    property p_rssi_msb;
        (3'(rssi_bit5_clocks_o) + 3'(rssi_bit4_clocks_o) == 3'd4) && (rssi_msb_timing_sel_o || rssi_bit5_clocks_o == 2'd3);
    endproperty
    a_rssi_msb: assert property (p_rssi_msb)
        else $error("RSSI MSB clock split is wrong.");

    property p_settle;
        rssi_settle_tau_o == (rssi_quick_settle_o ? 3'd2 : 3'd4);
    endproperty
    a_settle: assert property (p_settle)
        else $error("RSSI settle length disagrees with quick bit.");

    property p_cap;
        rssi_cap_trim_o == 2'b11 |-> rssi_cap_pf_o == 4'd12;
    endproperty
    a_cap: assert property (p_cap)
        else $error("Trim 11 does not select 12 pF.");

    property p_read_load;
        phase == receiver_tuning_pkg::PH_ADDR && sclk_rise && bit_cnt == 3'h7
            && {shift_in[5:0], pin_f[0]} == `RT_ADDR_DEMOD |=> sh_out == $past(demod_reg);
    endproperty
    a_read_load: assert property (p_read_load)
        else $error("Read of demodulator register loaded wrong data.");

endmodule

//--- serial_host_model.sv
// Behavioural microcontroller that drives the serial control pins of the tuning registers.
// Assumes the bench calls xfer from one process; pins change just after a falling clk edge.
`timescale 1ns/1ps

module serial_host_model (
    input wire logic clk_i,
    input wire logic spi_dout_i,
    input wire logic spi_dout_oe_i,
    output logic spi_clk_o,
    output logic spi_en_o,
    output logic spi_din_o
);
    // Eight clk cycles per half period, so the pin filter sees every serial level.
    localparam int HALF = 8;

    // Pins idle low with enable off until the first frame.
    initial begin
        spi_clk_o = 1'b0;
        spi_en_o = 1'b0;
        spi_din_o = 1'b0;
    end

    // Command byte then data byte, MSB first; fewer than 16 bits aborts the frame.
    task automatic xfer(input logic [15:0] frame, input int nbits, output logic [7:0] rd);
        rd = 8'h00;
        @(negedge clk_i);
        spi_en_o = 1'b1;
        for (int i = 15; i >= 16 - nbits; i--) begin
            spi_din_o = frame[i];
            repeat (HALF) @(negedge clk_i);
            spi_clk_o = 1'b1;
            // The read line has no pull; an undriven line reads inverted, so a missing enable shows up.
            if (i < 8) begin
                rd = {rd[6:0], spi_dout_oe_i ? spi_dout_i : ~spi_dout_i};
            end
            repeat (HALF) @(negedge clk_i);
            spi_clk_o = 1'b0;
        end
        // Flip the data line so a stale level never looks meaningful.
        spi_din_o = ~spi_din_o;
        spi_en_o = 1'b0;
        repeat (HALF) @(negedge clk_i);
    endtask
endmodule

//--- receiver_tuning_config_regs_bench.sv
// Self-checking bench for the tuning register pair: serial access, decoded settings, startup waits.
// Assumes serial_host_model as the microcontroller and a two-cycle microsecond tick.
`timescale 1ns/1ps

module receiver_tuning_config_regs_bench;
    localparam int US = 2;
    logic clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic osc_rdy = 1'b0;
    logic lock = 1'b0;
    logic spi_clk, spi_en, spi_din, dout, dout_oe, osc_done, lock_done, ask, frac;
    logic dual, wide, ctr, ew, cs, rm, qs;
    logic [5:0] del;
    logic [2:0] esc, hc, tau;
    logic [1:0] b5, b4, trim;
    logic [3:0] pf;
    logic [7:0] rd;
    logic [7:0] vals [4] = '{8'h00, 8'h55, 8'hAA, 8'hFF};
    int n_errors = 0;
    int n_tests = 0;
    wire logic [31:0] dec = {dual, wide, ctr, del, ew, esc, cs, hc, rm, b5, b4, qs, tau, trim, pf};

    // Free-running 100 MHz clock.
    always #5 clk_i = ~clk_i;

    receiver_tuning_config_regs #(.US_CYCLES(US)) receiver_tuning_config_regs_inst (
        .clk_i(clk_i), .nrst_i(nrst_i), .spi_clk_i(spi_clk), .spi_en_i(spi_en), .spi_din_i(spi_din),
        .osc_ready_flag_i(osc_rdy), .pll_lock_i(lock), .spi_dout_o(dout), .spi_dout_oe_o(dout_oe),
        .osc_settle_done_o(osc_done), .lock_settle_done_o(lock_done), .ask_filter_mid_reset_o(ask),
        .frac_n_disable_o(frac), .demod_dual_limiter_sel_o(dual), .demod_wide_range_o(wide),
        .demod_center_600k_o(ctr), .demod_delay_elements_o(del), .edge_window_wide_o(ew),
        .edge_sample_count_o(esc), .chip_timeout_short_o(cs), .chip_timeout_half_chips_o(hc),
        .rssi_msb_timing_sel_o(rm), .rssi_bit5_clocks_o(b5), .rssi_bit4_clocks_o(b4),
        .rssi_quick_settle_o(qs), .rssi_settle_tau_o(tau), .rssi_cap_trim_o(trim), .rssi_cap_pf_o(pf)
    );

    serial_host_model serial_host_model_inst (
        .clk_i(clk_i), .spi_dout_i(dout), .spi_dout_oe_i(dout_oe), .spi_clk_o(spi_clk), .spi_en_o(spi_en),
        .spi_din_o(spi_din)
    );

    // Expected decoded outputs for a demodulator register value, in the order of dec.
    function automatic logic [31:0] exp_dec(input logic [7:0] v);
        logic [5:0] dl;
        logic [3:0] cap;
        dl = (v[7:6] == 2'h0) ? 6'd40 : (v[7:6] == 2'h1) ? 6'd13 : (v[7:6] == 2'h2) ? 6'd20 : 6'd7;
        cap = (v[1:0] == 2'h0) ? 4'd0 : (v[1:0] == 2'h1) ? 4'd2 : (v[1:0] == 2'h2) ? 4'd5 : 4'd12;
        return {v[7], v[6], v[7], dl, v[5], v[5] ? 3'd4 : 3'd2, v[4], v[4] ? 3'd5 : 3'd7, v[3],
                v[3] ? 2'd2 : 2'd3, v[3] ? 2'd2 : 2'd1, v[2], v[2] ? 3'd2 : 3'd4, v[1:0], cap};
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Settle time after a write covers the pin filter and the output register.
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] unused;
        serial_host_model_inst.xfer({1'b0, a, d}, 16, unused);
        repeat (4) @(negedge clk_i);
    endtask

    task automatic rdchk(input logic [6:0] a, input logic [7:0] exp);
        serial_host_model_inst.xfer({1'b1, a, 8'hA5}, 16, rd);
        check({24'h0, rd}, {24'h0, exp});
    endtask

    // Raises one start level, counts cycles to done, allows one tick of slack, then drops it.
    task automatic timed(input bit sel_lock, input int t_us);
        int n;
        n = 0;
        if (sel_lock) lock = 1'b1;
        else osc_rdy = 1'b1;
        while ((sel_lock ? lock_done : osc_done) !== 1'b1 && n < 3000) begin
            @(negedge clk_i);
            n++;
        end
        check(32'(n >= t_us * US - US && n <= t_us * US + US + 3), 32'h1);
        lock = 1'b0;
        osc_rdy = 1'b0;
        repeat (2) @(negedge clk_i);
        check({31'h0, sel_lock ? lock_done : osc_done}, 32'h0);
    endtask

    task automatic end_sim();
        if (n_errors == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Main sequence: defaults, field decodes, startup waits, refusals.
    initial begin
        repeat (2) @(negedge clk_i);
        nrst_i = 1'b1;
        repeat (6) @(negedge clk_i);
        check(dec, exp_dec(8'h02));
        check({28'h0, osc_done, lock_done, ask, frac}, 32'h0);
        check({31'h0, dout_oe}, 32'h0);
        rdchk(7'h32, 8'h49);
        rdchk(7'h33, 8'h02);
        timed(0, 512);
        for (int i = 0; i < 4; i++) begin
            wr(7'h33, vals[i]);
            check(dec, exp_dec(vals[i]));
            rdchk(7'h33, vals[i]);
        end
        for (int k = 0; k < 4; k++) begin
            wr(7'h32, {k[1:0], k[0], 2'b10, k[1], k[1:0]});
            check({30'h0, ask, frac}, {30'h0, k[0], k[1]});
            rdchk(7'h32, {k[1:0], k[0], 2'b10, k[1], k[1:0]});
            timed(0, 256 * (k + 1));
            timed(1, 16 * (k + 1));
        end
        wr(7'h34, 8'h5A);
        rdchk(7'h34, 8'h00);
        rdchk(7'h33, 8'hFF);
        serial_host_model_inst.xfer({1'b0, 7'h33, 8'h00}, 10, rd);
        rdchk(7'h33, 8'hFF);
        // A reset in mid-run must bring both registers back from non-default contents.
        nrst_i = 1'b0;
        repeat (2) @(negedge clk_i);
        nrst_i = 1'b1;
        repeat (6) @(negedge clk_i);
        check(dec, exp_dec(8'h02));
        rdchk(7'h33, 8'h02);
        rdchk(7'h32, 8'h49);
        // Software puts the tuning settings back to their defaults before leaving them alone.
        wr(7'h32, 8'h49);
        wr(7'h33, 8'h02);
        check(dec, exp_dec(8'h02));
        rdchk(7'h32, 8'h49);
        end_sim();
    end

    // Watchdog well beyond the roughly 14000 cycles the sequence needs.
    initial begin
        repeat (40000) @(posedge clk_i);
        n_errors++;
        end_sim();
    end
endmodule
